// ===== hw/pcr_regs.vh
// Register offsets, field positions, reset values and constants of the proximity configuration bank
// Summary of operation
// - With both high-crosstalk select bits set, proximity results come out in a 10-bit format.
// - Results are averaged over a moving window of length equal to the 3-bit filter setting plus one.
// - With filtering, every result is evaluated when decimate is 0, else one result in every n+1 for filter setting n.
// - The release-phase sink current is scaled by bits 7:6 as 0.5, 1, 1.5 or 2.
// - The detect-phase sink current is scaled by bits 5:4 as 0.5, 1, 1.5 or 2.
// - The third emitter sink takes n mA from code n in the low nibble, 0 to 7 mA.
// - The second emitter sink takes n mA from code n in bits 7:4, up to 7 mA.
// - The first emitter sink takes n+1 mA from code n in bits 3:0, 1 to 8 mA.
`ifndef PCR_REGS_VH
`define PCR_REGS_VH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define PCR_IDX_FLICKER_BUFFER 8'ha7
`define PCR_IDX_PROX_AVERAGE_LENGTH 8'haa
`define PCR_IDX_SINK_SCALER 8'hab
`define PCR_IDX_SINK_CURRENT 8'hac
`define PCR_IDX_PROX_MODE 8'hc0

// ----------------------------------------
// Writable bit masks and reset values
// ----------------------------------------
`define PCR_MASK_FLICKER_BUFFER 8'h10
`define PCR_MASK_PROX_AVERAGE_LENGTH 8'h8f
`define PCR_MASK_SINK_SCALER 8'hff
`define PCR_MASK_SINK_CURRENT 8'hff
`define PCR_MASK_PROX_MODE 8'h01
`define PCR_RST_FLICKER_BUFFER 8'h00
`define PCR_RST_PROX_AVERAGE_LENGTH 8'h00
`define PCR_RST_SINK_SCALER 8'h00
`define PCR_RST_SINK_CURRENT 8'h00
`define PCR_RST_PROX_MODE 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCR_BIT_FLICKER_MODE 4
`define PCR_BIT_HXTALK_B 7
`define PCR_BIT_DECIMATE 3
`define PCR_BIT_HXTALK_A 0
`define PCR_LEN_HI 2
`define PCR_LEN_LO 0
`define PCR_RELEASE_HI 7
`define PCR_RELEASE_LO 6
`define PCR_DETECT_HI 5
`define PCR_DETECT_LO 4
`define PCR_EMIT_C_HI 3
`define PCR_EMIT_C_LO 0
`define PCR_EMIT_B_HI 7
`define PCR_EMIT_B_LO 4
`define PCR_EMIT_A_HI 3
`define PCR_EMIT_A_LO 0

// ----------------------------------------
// Widths and limits
// ----------------------------------------
`define PCR_SAMPLE_W 14
`define PCR_NARROW_W 10
`define PCR_NARROW_SHIFT 4
`define PCR_SUM_W 17
`define PCR_MAX_CODE 4'h7
`define PCR_RESP_OKAY 2'b00
`define PCR_RESP_DECODE 2'b11

`endif

// ===== hw/pcr_window_mem.v
// Eight-entry sample memory for the moving-average window, registered read
`timescale 1ns/1ps
module pcr_window_mem (
    clk,
    wr_en,
    wr_addr,
    wr_data,
    rd_addr,
    rd_data
);
    input wire clk;
    input wire wr_en;
    input wire [2:0] wr_addr;
    input wire [13:0] wr_data;
    input wire [2:0] rd_addr;
    output reg [13:0] rd_data;

    reg [13:0] mem [0:7];

    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== hw/pcr_prox_config.v
// Proximity configuration register bank with moving-average filter and sink current decode
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "pcr_regs.vh"
module pcr_prox_config (
    clk,
    sys_rst,
    avs_address,
    avs_byteenable,
    avs_read,
    avs_write,
    avs_writedata,
    avs_readdata,
    avs_response,
    avs_waitrequest,
    prox_sample,
    prox_sample_valid,
    prox_sample_ready,
    release_phase,
    prox_result,
    prox_result_valid,
    prox_eval,
    narrow_mode,
    flicker_buffer_mode,
    sink_scale_halves,
    emitter_a_current,
    emitter_b_current,
    emitter_c_current,
    emitter_a_drive,
    emitter_b_drive,
    emitter_c_drive
);
    input wire clk;
    input wire sys_rst;
    input wire [9:0] avs_address;
    input wire [3:0] avs_byteenable;
    input wire avs_read;
    input wire avs_write;
    input wire [31:0] avs_writedata;
    output reg [31:0] avs_readdata;
    output reg [1:0] avs_response;
    output wire avs_waitrequest;
    input wire [13:0] prox_sample;
    input wire prox_sample_valid;
    output wire prox_sample_ready;
    input wire release_phase;
    output reg [13:0] prox_result;
    output reg prox_result_valid;
    output reg prox_eval;
    output wire narrow_mode;
    output wire flicker_buffer_mode;
    output wire [2:0] sink_scale_halves;
    output wire [3:0] emitter_a_current;
    output wire [3:0] emitter_b_current;
    output wire [3:0] emitter_c_current;
    output reg [6:0] emitter_a_drive;
    output reg [6:0] emitter_b_drive;
    output reg [6:0] emitter_c_drive;

    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_ACC = 2'h2;
    localparam ST_OUT = 2'h3;

    reg [7:0] flicker_buffer_reg;
    reg [7:0] prox_average_length_reg;
    reg [7:0] sink_scaler_reg;
    reg [7:0] sink_current_reg;
    reg [7:0] prox_mode_reg;
    reg ack_reg;
    reg [1:0] state_reg;
    reg [13:0] new_reg;
    reg [2:0] wr_ptr_reg;
    reg [3:0] fill_reg;
    reg [16:0] sum_reg;
    reg [2:0] dec_reg;
    reg [16:0] sum_next;
    reg [7:0] rd_word;
    reg rd_hit;

    wire [7:0] word_idx;
    wire req;
    wire wr_take;
    wire [7:0] wbyte;
    wire [13:0] old_sample;
    wire [2:0] len_code;
    wire [3:0] win_len;
    wire [2:0] rd_slot;
    wire window_full;
    wire len_write;
    wire [13:0] avg_full;

    assign word_idx = avs_address[9:2];
    assign req = avs_read | avs_write;
    // One wait cycle on every access: the request is answered on its second edge
    assign avs_waitrequest = req & ~ack_reg;
    assign wr_take = avs_write & ack_reg & avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];

    // ----------------------------------------
    // Register bus slave
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always @* begin
        rd_hit = 1'b1;
        rd_word = 8'h00;
        case (word_idx)
            `PCR_IDX_FLICKER_BUFFER: rd_word = flicker_buffer_reg & `PCR_MASK_FLICKER_BUFFER;
            `PCR_IDX_PROX_AVERAGE_LENGTH: rd_word = prox_average_length_reg & `PCR_MASK_PROX_AVERAGE_LENGTH;
            `PCR_IDX_SINK_SCALER: rd_word = sink_scaler_reg;
            `PCR_IDX_SINK_CURRENT: rd_word = sink_current_reg;
            `PCR_IDX_PROX_MODE: rd_word = prox_mode_reg & `PCR_MASK_PROX_MODE;
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= `PCR_RESP_OKAY;
        end else if (req & ~ack_reg) begin
            avs_readdata <= avs_read ? {24'h00_0000, rd_word} : 32'h0000_0000;
            avs_response <= rd_hit ? `PCR_RESP_OKAY : `PCR_RESP_DECODE;
        end
    end

    // Reserved bits are masked off on write so they never hold a one
    always @(posedge clk) begin
        if (sys_rst) begin
            flicker_buffer_reg <= `PCR_RST_FLICKER_BUFFER;
            prox_average_length_reg <= `PCR_RST_PROX_AVERAGE_LENGTH;
            sink_scaler_reg <= `PCR_RST_SINK_SCALER;
            sink_current_reg <= `PCR_RST_SINK_CURRENT;
            prox_mode_reg <= `PCR_RST_PROX_MODE;
        end else if (wr_take) begin
            case (word_idx)
                `PCR_IDX_FLICKER_BUFFER: flicker_buffer_reg <= wbyte & `PCR_MASK_FLICKER_BUFFER;
                `PCR_IDX_PROX_AVERAGE_LENGTH: prox_average_length_reg <= wbyte & `PCR_MASK_PROX_AVERAGE_LENGTH;
                `PCR_IDX_SINK_SCALER: sink_scaler_reg <= wbyte & `PCR_MASK_SINK_SCALER;
                `PCR_IDX_SINK_CURRENT: sink_current_reg <= wbyte & `PCR_MASK_SINK_CURRENT;
                `PCR_IDX_PROX_MODE: prox_mode_reg <= wbyte & `PCR_MASK_PROX_MODE;
                default: prox_mode_reg <= prox_mode_reg;
            endcase
        end
    end

    // ----------------------------------------
    // Configuration decode
    // ----------------------------------------
    assign flicker_buffer_mode = flicker_buffer_reg[`PCR_BIT_FLICKER_MODE];
    // Either bit alone leaves the full-width format in place
    assign narrow_mode = prox_average_length_reg[`PCR_BIT_HXTALK_B] & prox_mode_reg[`PCR_BIT_HXTALK_A];
    assign len_code = prox_average_length_reg[`PCR_LEN_HI:`PCR_LEN_LO];
    assign win_len = {1'b0, len_code} + 4'h1;
    // Scaler in half steps: code 0..3 gives 1..4 halves, that is 0.5x to 2x
    assign sink_scale_halves = release_phase ?
        ({1'b0, sink_scaler_reg[`PCR_RELEASE_HI:`PCR_RELEASE_LO]} + 3'h1) :
        ({1'b0, sink_scaler_reg[`PCR_DETECT_HI:`PCR_DETECT_LO]} + 3'h1);

    // Codes above 7 are illegal; clamping keeps a bad write from overdriving the sinks
    function [3:0] clamp_code;
        input [3:0] code;
        begin
            clamp_code = (code > `PCR_MAX_CODE) ? `PCR_MAX_CODE : code;
        end
    endfunction

    assign emitter_a_current = clamp_code(sink_current_reg[`PCR_EMIT_A_HI:`PCR_EMIT_A_LO]) + 4'h1;
    assign emitter_b_current = clamp_code(sink_current_reg[`PCR_EMIT_B_HI:`PCR_EMIT_B_LO]);
    assign emitter_c_current = clamp_code(sink_scaler_reg[`PCR_EMIT_C_HI:`PCR_EMIT_C_LO]);

    // Drive in half milliamps: current times the active phase scaler
    always @(posedge clk) begin
        if (sys_rst) begin
            emitter_a_drive <= 7'h00;
            emitter_b_drive <= 7'h00;
            emitter_c_drive <= 7'h00;
        end else begin
            emitter_a_drive <= {3'h0, emitter_a_current} * {4'h0, sink_scale_halves};
            emitter_b_drive <= {3'h0, emitter_b_current} * {4'h0, sink_scale_halves};
            emitter_c_drive <= {3'h0, emitter_c_current} * {4'h0, sink_scale_halves};
        end
    end

    // ----------------------------------------
    // Moving-average filter
    // ----------------------------------------
    assign prox_sample_ready = (state_reg == ST_IDLE);
    assign window_full = (fill_reg == win_len);
    // Oldest sample of the window leaves when a new one arrives on a full window
    assign rd_slot = wr_ptr_reg - len_code - 3'h1;
    // A length change restarts the window so stale samples never mix in
    assign len_write = wr_take & (word_idx == `PCR_IDX_PROX_AVERAGE_LENGTH) &
        (wbyte[`PCR_LEN_HI:`PCR_LEN_LO] != len_code);

    pcr_window_mem u_mem (
        .clk(clk),
        .wr_en(state_reg == ST_ACC),
        .wr_addr(wr_ptr_reg),
        .wr_data(new_reg),
        .rd_addr(rd_slot),
        .rd_data(old_sample)
    );

    always @* begin
        sum_next = sum_reg + {3'h0, new_reg};
        if (window_full) begin
            sum_next = sum_next - {3'h0, old_sample};
        end
    end

    function [16:0] divide_sum;
        input [16:0] s;
        input [3:0] n;
        begin
            case (n)
                4'h1: divide_sum = s;
                4'h2: divide_sum = s / 17'd2;
                4'h3: divide_sum = s / 17'd3;
                4'h4: divide_sum = s / 17'd4;
                4'h5: divide_sum = s / 17'd5;
                4'h6: divide_sum = s / 17'd6;
                4'h7: divide_sum = s / 17'd7;
                4'h8: divide_sum = s / 17'd8;
                default: divide_sum = s;
            endcase
        end
    endfunction

    wire [16:0] avg_wide;
    assign avg_wide = divide_sum(sum_reg, fill_reg);
    assign avg_full = avg_wide[13:0];

    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            new_reg <= 14'h0000;
            wr_ptr_reg <= 3'h0;
            fill_reg <= 4'h0;
            sum_reg <= 17'h0_0000;
            dec_reg <= 3'h0;
            prox_result <= 14'h0000;
            prox_result_valid <= 1'b0;
            prox_eval <= 1'b0;
        end else begin
            prox_result_valid <= 1'b0;
            prox_eval <= 1'b0;
            if (len_write) begin
                state_reg <= ST_IDLE;
                fill_reg <= 4'h0;
                sum_reg <= 17'h0_0000;
                dec_reg <= 3'h0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (prox_sample_valid) begin
                            new_reg <= prox_sample;
                            state_reg <= ST_READ;
                        end
                    end
                    ST_READ: begin
                        state_reg <= ST_ACC;
                    end
                    ST_ACC: begin
                        sum_reg <= sum_next;
                        wr_ptr_reg <= wr_ptr_reg + 3'h1;
                        if (!window_full) begin
                            fill_reg <= fill_reg + 4'h1;
                        end
                        state_reg <= ST_OUT;
                    end
                    ST_OUT: begin
                        if (narrow_mode) begin
                            prox_result <= {4'h0, avg_full[13:`PCR_NARROW_SHIFT]};
                        end else begin
                            prox_result <= avg_full;
                        end
                        prox_result_valid <= 1'b1;
                        if (!prox_average_length_reg[`PCR_BIT_DECIMATE]) begin
                            prox_eval <= 1'b1;
                        end else if (dec_reg == len_code) begin
                            prox_eval <= 1'b1;
                            dec_reg <= 3'h0;
                        end else begin
                            dec_reg <= dec_reg + 3'h1;
                        end
                        state_reg <= ST_IDLE;
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ===== verif/pcr_prox_config_assertions.sv
// Port-level checks for the proximity configuration bank
`timescale 1ns/1ps
module pcr_prox_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [9:0] avs_address,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic prox_sample_valid,
    input wire logic prox_sample_ready,
    input wire logic release_phase,
    input wire logic prox_result_valid,
    input wire logic prox_eval,
    input wire logic narrow_mode,
    input wire logic [2:0] sink_scale_halves,
    input wire logic [3:0] emitter_a_current,
    input wire logic [3:0] emitter_b_current,
    input wire logic [3:0] emitter_c_current
);
    // ----------------------------------------
    // Shadow of writable fields
    // ----------------------------------------
    logic [7:0] sh_filt, sh_scal, sh_cur, sh_mode;
    wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    function automatic logic [3:0] clp(input logic [3:0] c);
        return (c > 4'h7) ? 4'h7 : c;
    endfunction
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_filt <= 8'h00;
            sh_scal <= 8'h00;
            sh_cur <= 8'h00;
            sh_mode <= 8'h00;
        end else if (wr_ok) begin
            case (avs_address[9:2])
                8'haa: sh_filt <= avs_writedata[7:0];
                8'hab: sh_scal <= avs_writedata[7:0];
                8'hac: sh_cur <= avs_writedata[7:0];
                8'hc0: sh_mode <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_narrow; narrow_mode == (sh_filt[7] & sh_mode[0]); endproperty
    a_narrow: assert property (p_narrow) else $error("narrow mode mismatch");
    // A filter write may abort a sample in flight, so such a cycle drops the attempt
    property p_take; disable iff (sys_rst || (avs_write && avs_address[9:2] == 8'haa))
        prox_sample_valid && prox_sample_ready |=> !prox_sample_ready [*3] ##1
        (prox_sample_ready && prox_result_valid); endproperty
    a_take: assert property (p_take) else $error("result timing wrong");
    property p_every; prox_result_valid && !sh_filt[3] |-> prox_eval; endproperty
    a_every: assert property (p_every) else $error("result not evaluated");
    property p_evpulse; prox_eval |-> prox_result_valid; endproperty
    a_evpulse: assert property (p_evpulse) else $error("eval without result");
    property p_rel; release_phase |-> sink_scale_halves == {1'b0, sh_scal[7:6]} + 3'h1; endproperty
    a_rel: assert property (p_rel) else $error("release scaler wrong");
    property p_det; !release_phase |-> sink_scale_halves == {1'b0, sh_scal[5:4]} + 3'h1; endproperty
    a_det: assert property (p_det) else $error("detect scaler wrong");
    property p_emc; emitter_c_current == clp(sh_scal[3:0]); endproperty
    a_emc: assert property (p_emc) else $error("emitter c current wrong");
    property p_emb; emitter_b_current == clp(sh_cur[7:4]); endproperty
    a_emb: assert property (p_emb) else $error("emitter b current wrong");
    property p_ema; emitter_a_current == clp(sh_cur[3:0]) + 4'h1; endproperty
    a_ema: assert property (p_ema) else $error("emitter a current wrong");
    property p_rsvd; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000 &&
        (avs_address[9:2] != 8'haa || avs_readdata[6:4] == 3'h0); endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    c_take: cover property (prox_sample_valid && prox_sample_ready);
    c_decim: cover property (prox_eval && sh_filt[3]);
    c_narrow: cover property (narrow_mode && prox_result_valid);
endmodule
bind pcr_prox_config pcr_prox_checker chk (.clk, .sys_rst, .avs_address, .avs_byteenable, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .prox_sample_valid, .prox_sample_ready,
    .release_phase, .prox_result_valid, .prox_eval, .narrow_mode, .sink_scale_halves, .emitter_a_current,
    .emitter_b_current, .emitter_c_current);

// ===== verif/test_pcr_prox_config.sv
// Self-checking bench for the proximity configuration bank
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module test_pcr_prox_config;
    logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, prox_sample_valid = 1'b0;
    logic release_phase = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 32'h0000_0000, rd;
    logic [13:0] prox_sample = 14'h0000;
    logic [1:0] rsp, sc;
    logic [3:0] cd;
    logic [2:0] h;
    wire [31:0] avs_readdata;
    wire [1:0] avs_response;
    wire avs_waitrequest, prox_sample_ready, prox_result_valid, prox_eval, narrow_mode, flicker_buffer_mode;
    wire [13:0] prox_result;
    wire [2:0] sink_scale_halves;
    wire [3:0] emitter_a_current, emitter_b_current, emitter_c_current;
    wire [6:0] emitter_a_drive, emitter_b_drive, emitter_c_drive;
    int fails = 0, tests_run = 0, n;
    logic [7:0] idx [5] = '{8'ha7, 8'haa, 8'hab, 8'hac, 8'hc0};
    logic [7:0] wpat [5] = '{8'hff, 8'hff, 8'hf7, 8'h77, 8'hff};
    logic [7:0] rmsk [5] = '{8'h10, 8'h8f, 8'hf7, 8'h77, 8'h01};
    logic [13:0] s1 [4] = '{14'h0064, 14'h00c8, 14'h012c, 14'h0190};
    logic [13:0] r1 [4] = '{14'h0064, 14'h0096, 14'h00c8, 14'h012c};
    logic [13:0] s2 [4] = '{14'h000a, 14'h0014, 14'h001e, 14'h0028};
    logic [13:0] r2 [4] = '{14'h000a, 14'h000f, 14'h0019, 14'h0023};
    always #2.5 clk = ~clk;
    pcr_prox_config uut (.clk, .sys_rst, .avs_address, .avs_byteenable, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_response, .avs_waitrequest, .prox_sample, .prox_sample_valid,
        .prox_sample_ready, .release_phase, .prox_result, .prox_result_valid, .prox_eval, .narrow_mode,
        .flicker_buffer_mode, .sink_scale_halves, .emitter_a_current, .emitter_b_current,
        .emitter_c_current, .emitter_a_drive, .emitter_b_drive, .emitter_c_drive);
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task give_verdict;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task guard;
        if (n >= 50) begin
            fails++;
            give_verdict;
        end
    endtask
    // Waitrequest is looked at mid-cycle, so the take edge is the next rising one
    task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge clk);
        avs_address <= {i, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h00_0000, d};
        n = 0;
        do begin @(negedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
        guard;
        @(posedge clk);
        rd = avs_readdata;
        rsp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
        `CHK(rsp, 2'b00)
    endtask
    task rdc(input logic [7:0] i, input logic [7:0] e);
        bus(1'b0, i, 8'h00);
        `CHK(rd, {24'h00_0000, e})
        `CHK(rsp, 2'b00)
    endtask
    task samp(input logic [13:0] s, input logic [13:0] r, input logic e);
        @(posedge clk);
        prox_sample <= s;
        prox_sample_valid <= 1'b1;
        n = 0;
        do begin @(negedge clk); n++; end while (prox_sample_ready !== 1'b1 && n < 50);
        guard;
        @(posedge clk);
        prox_sample_valid <= 1'b0;
        n = 0;
        do begin @(negedge clk); n++; end while (prox_result_valid !== 1'b1 && n < 50);
        guard;
        `CHK(prox_result, r)
        `CHK(prox_eval, e)
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 5; k++) rdc(idx[k], 8'h00);
        for (int k = 0; k < 5; k++) begin
            wr(idx[k], wpat[k]);
            rdc(idx[k], rmsk[k]);
        end
        @(negedge clk);
        `CHK(narrow_mode, 1'b1)
        `CHK(flicker_buffer_mode, 1'b1)
        wr(8'hc0, 8'h00);
        @(negedge clk);
        `CHK(narrow_mode, 1'b0)
        bus(1'b0, 8'ha8, 8'h00);
        `CHK(rsp, 2'b11)
        `CHK(rd, 32'h0000_0000)
        for (int c = 0; c < 8; c++) begin
            cd = 4'(c);
            sc = 2'(c);
            wr(8'hac, {cd, cd});
            wr(8'hab, {sc, ~sc, cd});
            for (int p = 0; p < 2; p++) begin
                @(posedge clk);
                release_phase <= p[0];
                repeat (2) @(negedge clk);
                h = p ? {1'b0, sc} + 3'h1 : {1'b0, ~sc} + 3'h1;
                `CHK(sink_scale_halves, h)
                `CHK(emitter_a_current, cd + 4'h1)
                `CHK(emitter_b_current, cd)
                `CHK(emitter_c_current, cd)
                `CHK(emitter_a_drive, 7'(cd + 4'h1) * 7'(h))
                `CHK(emitter_b_drive, 7'(cd) * 7'(h))
                `CHK(emitter_c_drive, 7'(cd) * 7'(h))
            end
        end
        wr(8'haa, 8'h02);
        for (int k = 0; k < 4; k++) samp(s1[k], r1[k], 1'b1);
        wr(8'haa, 8'h09);
        for (int k = 0; k < 4; k++) samp(s2[k], r2[k], 1'(k % 2));
        wr(8'haa, 8'h07);
        for (int k = 0; k < 8; k++) samp(14'h3fff, 14'h3fff, 1'b1);
        samp(14'h0000, 14'h37ff, 1'b1);
        wr(8'hc0, 8'h01);
        wr(8'haa, 8'h80);
        @(negedge clk);
        `CHK(narrow_mode, 1'b1)
        samp(14'h3fff, 14'h03ff, 1'b1);
        give_verdict;
    end
endmodule
